/* line_core_reset_pkg.sv */
// constants and types shared by the line-core reset control block
package line_core_reset_pkg;

    // clock rate and the least reset hold time
    localparam int CLK_FREQ_MHZ = 125;
    localparam int RST_HOLD_NS  = 8;
    localparam int RST_HOLD_RAW = (RST_HOLD_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int RST_HOLD_CYC = (RST_HOLD_RAW < 1) ? 1 : RST_HOLD_RAW;

    // width of the hold counter in each reset channel
    localparam int HOLD_CNT_W = 3;

    // index of each line-core sub-block
    localparam int SUB_COUNT  = 4;
    localparam int SUB_TX_SER = 0;
    localparam int SUB_TX_PLL = 1;
    localparam int SUB_RX_DES = 2;
    localparam int SUB_RX_PLL = 3;

    // reset values of the control flops
    localparam logic RST_VAL_ASSERTED = 1'h1;
    localparam logic RST_VAL_IO_DRIVE = 1'h0;
    localparam logic RST_VAL_SLEEP    = 1'h0;

    // phase of the device as seen by the reset control
    typedef enum logic [1:0]
    {
        PH_POWERUP,
        PH_CONFIG,
        PH_RUN
    } phase_t;

endpackage

/* core_reset_if.sv */
// carrier between the reset control and one sub-block reset channel
`timescale 1ns/10ps
interface core_reset_if;
    logic assert_req;   // reset wanted for this sub-block
    logic sync_sel;     // release through the two-stage synchroniser
    logic rst;          // reset level to the sub-block

    modport ctl
    (
        output assert_req,
        output sync_sel,
        input  rst
    );

    modport chan
    (
        input  assert_req,
        input  sync_sel,
        output rst
    );
endinterface

/* core_reset_channel.sv */
// one sub-block reset: immediate assert, least hold, optional synchronised release
`timescale 1ns/10ps
module core_reset_channel
    import line_core_reset_pkg::*;
(
    input  wire logic    i_clk,   // block clock
    input  wire logic    i_rst,   // synchronous reset, active high
    core_reset_if.chan   bus      // request in, reset level out
);

    logic [HOLD_CNT_W-1:0] hold_r;
    logic [HOLD_CNT_W-1:0] hold_nxt;
    logic                  sync1_r;
    logic                  sync1_nxt;
    logic                  sync2_r;
    logic                  sync2_nxt;
    logic                  rst_r;
    logic                  rst_nxt;

    // next state: a request asserts at the next edge and reloads the hold
    always_comb
    begin
        hold_nxt  = hold_r;
        sync1_nxt = 1'h0;
        sync2_nxt = sync1_r;
        rst_nxt   = 1'h0;
        if (bus.assert_req)
        begin
            hold_nxt  = HOLD_CNT_W'(RST_HOLD_CYC);
            sync1_nxt = 1'h1;
            sync2_nxt = 1'h1;
            rst_nxt   = 1'h1;
        end
        else if (hold_r != '0)
        begin
            hold_nxt  = hold_r - HOLD_CNT_W'(1);
            sync1_nxt = 1'h1;
            sync2_nxt = 1'h1;
            rst_nxt   = 1'h1;
        end
        else if (bus.sync_sel)
        begin
            rst_nxt = sync2_r;
        end
        else
        begin
            sync2_nxt = 1'h0;
        end
    end

    // registers
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            hold_r  <= HOLD_CNT_W'(RST_HOLD_CYC);
            sync1_r <= RST_VAL_ASSERTED;
            sync2_r <= RST_VAL_ASSERTED;
            rst_r   <= RST_VAL_ASSERTED;
        end
        else
        begin
            hold_r  <= hold_nxt;
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            rst_r   <= rst_nxt;
        end
    end

    assign bus.rst = rst_r;

endmodule

/* line_core_reset_control.sv */
// reset, power-down and output float control for the embedded line core
// Contract
// - at power-up both the line core and the programmable fabric are reset.
// - during power-up all four sub-blocks are in reset and the embedded I/O floats.
// - during fabric configuration all four sub-blocks are in reset and the I/O is driven.
// - the transmit reset pin resets only the transmit serializer and transmit PLL.
// - the receive reset pin resets only the receive deserializer and receive PLL.
// - the PLL sleep pin powers down both PLLs, resets nothing and keeps the I/O driven.
// - resets take effect at once and each reset stands for at least 8 ns.
// - second-version silicon offers a mode with immediate assert and synchronous release.
`timescale 1ns/10ps
module line_core_reset_control
    import line_core_reset_pkg::*;
(
    input  wire logic i_clk,                   // block clock, 125 MHz
    input  wire logic i_rst,                   // synchronous reset, active high
    input  wire logic i_powerup,               // power-on detect, high while powering up
    input  wire logic i_fabric_config,         // high while the fabric is being configured
    input  wire logic i_fabric_rst_req,        // fabric reset asked by the controller
    input  wire logic i_global_output_float,   // float all embedded I/O
    input  wire logic i_tx_reset,              // transmit side reset pin
    input  wire logic i_rx_reset,              // receive side reset pin
    input  wire logic i_pll_sleep_pin,         // power down both PLLs
    input  wire logic i_silicon_rev2,          // strap: second-version silicon
    input  wire logic i_sync_release_sel,      // select synchronous release
    output logic      o_tx_serializer_rst,     // reset to transmit_serializer
    output logic      o_tx_pll_rst,            // reset to transmit PLL
    output logic      o_rx_deserializer_rst,   // reset to receive_deserializer
    output logic      o_rx_pll_rst,            // reset to receive PLL
    output logic      o_tx_pll_sleep,          // power-down to transmit PLL
    output logic      o_rx_pll_sleep,          // power-down to receive PLL
    output logic      o_io_drive_en,           // embedded I/O driven when high
    output logic      o_fabric_rst,            // reset to the programmable fabric
    output logic      o_sync_release_act,      // synchronous release in force
    output logic      o_core_ready             // all sub-blocks out of reset
);

    // --- phase tracking ---
    phase_t phase_r;
    phase_t phase_nxt;

    // strap and mode state
    logic   rev2_r;
    logic   rev2_nxt;
    logic   sync_act_r;
    logic   sync_act_nxt;

    // pin-facing control flops
    logic   io_drive_r;
    logic   io_drive_nxt;
    logic   sleep_r;
    logic   sleep_nxt;
    logic   fabric_rst_r;
    logic   fabric_rst_nxt;
    logic   ready_r;
    logic   ready_nxt;

    // per sub-block reset request
    logic [SUB_COUNT-1:0] req;
    logic [SUB_COUNT-1:0] chan_rst;

    // true when a sub-block belongs to the transmit side
    function automatic logic is_tx(input int idx);
        return (idx == SUB_TX_SER) || (idx == SUB_TX_PLL);
    endfunction

    // phase next value: power-up dominates configuration
    always_comb
    begin
        case (phase_r)
            PH_POWERUP:
            begin
                if (i_powerup)
                begin
                    phase_nxt = PH_POWERUP;
                end
                else if (i_fabric_config)
                begin
                    phase_nxt = PH_CONFIG;
                end
                else
                begin
                    phase_nxt = PH_RUN;
                end
            end
            PH_CONFIG, PH_RUN:
            begin
                if (i_powerup)
                begin
                    phase_nxt = PH_POWERUP;
                end
                else if (i_fabric_config)
                begin
                    phase_nxt = PH_CONFIG;
                end
                else
                begin
                    phase_nxt = PH_RUN;
                end
            end
            default:
            begin
                phase_nxt = PH_POWERUP;
            end
        endcase
    end

    // strap is caught while reset stands; release mode follows the select on second-version silicon only
    always_comb
    begin
        rev2_nxt     = rev2_r;
        sync_act_nxt = rev2_r & i_sync_release_sel;
    end

    // reset requests per sub-block
    always_comb
    begin
        for (int i = 0; i < SUB_COUNT; i++)
        begin
            req[i] = i_powerup || (phase_r == PH_POWERUP);
            req[i] = req[i] || i_fabric_config;
            if (is_tx(i))
            begin
                req[i] = req[i] || i_tx_reset;
            end
            else
            begin
                req[i] = req[i] || i_rx_reset;
            end
        end
    end

    // I/O drive, PLL sleep, fabric reset and ready status
    always_comb
    begin
        io_drive_nxt   = !(i_powerup || (phase_nxt == PH_POWERUP))
                         && !i_global_output_float;
        sleep_nxt      = i_pll_sleep_pin;
        fabric_rst_nxt = i_powerup || (phase_nxt == PH_POWERUP)
                         || i_fabric_rst_req;
        ready_nxt      = (chan_rst == '0) && (phase_r == PH_RUN);
    end

    // one reset channel per sub-block
    core_reset_if chan_if [SUB_COUNT] ();

    for (genvar g = 0; g < SUB_COUNT; g++)
    begin : g_chan
        assign chan_if[g].assert_req = req[g];
        assign chan_if[g].sync_sel   = sync_act_r;
        assign chan_rst[g]           = chan_if[g].rst;

        core_reset_channel u_chan
        (
            .i_clk (i_clk),
            .i_rst (i_rst),
            .bus   (chan_if[g])
        );
    end

    // registers
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            phase_r      <= PH_POWERUP;
            rev2_r       <= i_silicon_rev2;
            sync_act_r   <= 1'h0;
            io_drive_r   <= RST_VAL_IO_DRIVE;
            sleep_r      <= RST_VAL_SLEEP;
            fabric_rst_r <= RST_VAL_ASSERTED;
            ready_r      <= 1'h0;
        end
        else
        begin
            phase_r      <= phase_nxt;
            rev2_r       <= rev2_nxt;
            sync_act_r   <= sync_act_nxt;
            io_drive_r   <= io_drive_nxt;
            sleep_r      <= sleep_nxt;
            fabric_rst_r <= fabric_rst_nxt;
            ready_r      <= ready_nxt;
        end
    end

    // outputs, each from a flop
    assign o_tx_serializer_rst   = chan_rst[SUB_TX_SER];
    assign o_tx_pll_rst          = chan_rst[SUB_TX_PLL];
    assign o_rx_deserializer_rst = chan_rst[SUB_RX_DES];
    assign o_rx_pll_rst          = chan_rst[SUB_RX_PLL];
    assign o_tx_pll_sleep        = sleep_r;
    assign o_rx_pll_sleep        = sleep_r;
    assign o_io_drive_en         = io_drive_r;
    assign o_fabric_rst          = fabric_rst_r;
    assign o_sync_release_act    = sync_act_r;
    assign o_core_ready          = ready_r;

endmodule

/* line_core_reset_control_properties.sv */
// port-level assertions for the line-core reset control
`timescale 1ns/10ps
module line_core_reset_props
(
    input  wire logic i_clk,                 // block clock
    input  wire logic i_rst,                 // sync reset
    input  wire logic i_powerup,             // power-on
    input  wire logic i_fabric_config,       // configuring
    input  wire logic i_fabric_rst_req,      // fabric reset ask
    input  wire logic i_global_output_float, // float i/o
    input  wire logic i_tx_reset,            // tx pin
    input  wire logic i_rx_reset,            // rx pin
    input  wire logic i_pll_sleep_pin,       // pll sleep pin
    input  wire logic o_tx_serializer_rst,   // tx serializer reset
    input  wire logic o_tx_pll_rst,          // tx pll reset
    input  wire logic o_rx_deserializer_rst, // rx deserializer reset
    input  wire logic o_rx_pll_rst,          // rx pll reset
    input  wire logic o_tx_pll_sleep,        // tx pll sleep
    input  wire logic o_rx_pll_sleep,        // rx pll sleep
    input  wire logic o_io_drive_en,         // i/o driven
    input  wire logic o_fabric_rst,          // fabric reset
    input  wire logic o_sync_release_act,    // sync release on
    input  wire logic o_core_ready           // core ready
);
    logic [1:0] rst_d_r = 2'h3;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // reset history, so follow checks skip the edges just after release
    always_ff @(posedge i_clk)
    begin
        rst_d_r <= {rst_d_r[0], i_rst};
    end
    // a cycle in which some cause asks for the transmit side reset
    sequence tx_hit;
        (i_tx_reset | i_powerup | i_fabric_config);
    endsequence
    sequence tx_quiet;
        !(i_tx_reset | i_powerup | i_fabric_config);
    endsequence
    // a cycle in which some cause asks for the receive side reset
    sequence rx_hit;
        (i_rx_reset | i_powerup | i_fabric_config);
    endsequence
    sequence rx_quiet;
        !(i_rx_reset | i_powerup | i_fabric_config);
    endsequence
    AST_FLOAT: assert property
        (rst_d_r == 2'h0 |-> o_io_drive_en == !$past(i_powerup | i_global_output_float))
        else $error("io drive wrong");
    AST_SLEEP: assert property
        (rst_d_r == 2'h0 |-> o_tx_pll_sleep == $past(i_pll_sleep_pin) && o_rx_pll_sleep == o_tx_pll_sleep)
        else $error("pll sleep wrong");
    AST_FABRIC: assert property
        (rst_d_r == 2'h0 |-> o_fabric_rst == $past(i_powerup | i_fabric_rst_req))
        else $error("fabric reset wrong");
    AST_TX_ON: assert property
        (tx_hit |=> o_tx_serializer_rst && o_tx_pll_rst)
        else $error("tx reset late");
    AST_RX_ON: assert property
        (rx_hit |=> o_rx_deserializer_rst && o_rx_pll_rst)
        else $error("rx reset late");
    AST_TX_OFF: assert property
        (tx_quiet [*5] |=> !o_tx_serializer_rst && !o_tx_pll_rst)
        else $error("tx reset stuck");
    AST_RX_OFF: assert property
        (rx_quiet [*5] |=> !o_rx_deserializer_rst && !o_rx_pll_rst)
        else $error("rx reset stuck");
    AST_SYNC_HOLD: assert property
        (o_sync_release_act && i_tx_reset |=> o_tx_serializer_rst [*4])
        else $error("sync release early");
    AST_ASYNC_HOLD: assert property
        (!o_sync_release_act && i_rx_reset |=> o_rx_deserializer_rst [*2])
        else $error("reset too short");
    AST_READY: assert property
        (o_core_ready |-> $past(!(o_tx_serializer_rst | o_tx_pll_rst
                                  | o_rx_deserializer_rst | o_rx_pll_rst)))
        else $error("ready with reset");
endmodule

/* board_reset_host.sv */
// board controller model that walks the core bring-up
`timescale 1ns/10ps
module board_reset_host
(
    input  wire logic i_clk,            // block clock
    input  wire logic i_go,             // start bring-up
    output logic      o_tx_reset,       // tx reset pin
    output logic      o_rx_reset,       // rx reset pin
    output logic      o_fabric_rst_req, // fabric reset ask
    output logic      o_done            // sequence over
);
    int cnt_r = 0;
    // step counter, restarted by go
    always @(posedge i_clk)
    begin
        if (i_go)
            cnt_r <= 1;
        else if (cnt_r != 0 && cnt_r < 16)
            cnt_r <= cnt_r + 1;
    end
    // core pins high 4 cycles (32 ns) together with fabric reset
    assign o_tx_reset = (cnt_r >= 1 && cnt_r <= 4);
    assign o_rx_reset = o_tx_reset;
    // fabric let go well after the core is out
    assign o_fabric_rst_req = (cnt_r >= 1 && cnt_r <= 14);
    assign o_done = (cnt_r == 16);
endmodule

/* line_core_reset_control_tb.sv */
// self-checking bench for the line-core reset control
`timescale 1ns/10ps
module line_core_reset_control_tb;
    import line_core_reset_pkg::*;
    logic        i_clk = 1'h0;
    logic        i_rst = 1'h1;
    logic        rev2 = 1'h0;
    logic        h_go = 1'h0;
    logic        sel = 1'h1;
    logic [6:0]  drv = 7'h40;
    logic [9:0]  outs;
    logic        h_tx, h_rx, h_fab, h_done;
    int          err_total = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          n;
    logic [16:0] rows [8] = '{{7'h40, 10'h3c4}, {7'h20, 10'h3c8}, {7'h08, 10'h001},
        {7'h04, 10'h308}, {7'h02, 10'h0c8}, {7'h01, 10'h039}, {7'h10, 10'h00d},
        {7'h00, 10'h009}};
    // device under test
    line_core_reset_control u_line_core_reset_control
    (
        .i_clk                 (i_clk),
        .i_rst                 (i_rst),
        .i_powerup             (drv[6]),
        .i_fabric_config       (drv[5]),
        .i_fabric_rst_req      (drv[4] | h_fab),
        .i_global_output_float (drv[3]),
        .i_tx_reset            (drv[2] | h_tx),
        .i_rx_reset            (drv[1] | h_rx),
        .i_pll_sleep_pin       (drv[0]),
        .i_silicon_rev2        (rev2),
        .i_sync_release_sel    (sel),
        .o_tx_serializer_rst   (outs[9]),
        .o_tx_pll_rst          (outs[8]),
        .o_rx_deserializer_rst (outs[7]),
        .o_rx_pll_rst          (outs[6]),
        .o_tx_pll_sleep        (outs[5]),
        .o_rx_pll_sleep        (outs[4]),
        .o_io_drive_en         (outs[3]),
        .o_fabric_rst          (outs[2]),
        .o_sync_release_act    (outs[1]),
        .o_core_ready          (outs[0])
    );
    board_reset_host u_board_reset_host
    (
        .i_clk            (i_clk),
        .i_go             (h_go),
        .o_tx_reset       (h_tx),
        .o_rx_reset       (h_rx),
        .o_fabric_rst_req (h_fab),
        .o_done           (h_done)
    );
    always #4 i_clk = ~i_clk;
    // hang guard
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total = err_total + 1;
            close_out();
        end
    end
    task automatic step(input int k);
        repeat (k) @(posedge i_clk);
    endtask
    task automatic cmp(input logic [9:0] got, input logic [9:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_cnt(input int got, input int exp, input string what);
        check_count++;
        if (got != exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
        end
    endtask
    // one-cycle tx pulse, returns edges until the serializer reset drops
    task automatic measure(output int m);
        step(1);
        drv <= 7'h04;
        step(1);
        drv <= 7'h00;
        m = 0;
        do
        begin
            step(1);
            m++;
            #1;
        end while (outs[9] !== 1'h0 && m < 20);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        step(3);
        #1 cmp(outs, 10'h3c4, "in reset");
        step(1);
        i_rst <= 1'h0;
        foreach (rows[i])
        begin
            step(1);
            drv <= rows[i][16:10];
            step(8);
            #1 cmp(outs, rows[i][9:0], "row");
        end
        measure(n);
        cmp_cnt(n, RST_HOLD_CYC + 1, "async release");
        step(1);
        i_rst <= 1'h1;
        rev2 <= 1'h1;
        drv <= 7'h40;
        step(3);
        i_rst <= 1'h0;
        step(4);
        drv <= 7'h00;
        step(8);
        #1 cmp(outs, 10'h00b, "sync mode on");
        measure(n);
        cmp_cnt(n, RST_HOLD_CYC + 3, "sync release");
        step(1);
        h_go <= 1'h1;
        step(1);
        h_go <= 1'h0;
        step(6);
        #1;
        n = 0;
        while (outs[0] !== 1'h1 && n < 40)
        begin
            step(1);
            n++;
            #1;
        end
        cmp(outs, 10'h00f, "core up, fabric held");
        while (h_done !== 1'h1 && n < 80)
        begin
            step(1);
            n++;
            #1;
        end
        step(2);
        #1 cmp(outs, 10'h00b, "fabric released");
        // dropping the select falls back to immediate release
        step(1);
        sel <= 1'h0;
        step(2);
        #1 cmp(outs, 10'h009, "sync mode off");
        measure(n);
        cmp_cnt(n, RST_HOLD_CYC + 1, "async again");
        close_out();
    end
endmodule
bind line_core_reset_control line_core_reset_props u_line_core_reset_props
(
    .i_clk                 (i_clk),
    .i_rst                 (i_rst),
    .i_powerup             (i_powerup),
    .i_fabric_config       (i_fabric_config),
    .i_fabric_rst_req      (i_fabric_rst_req),
    .i_global_output_float (i_global_output_float),
    .i_tx_reset            (i_tx_reset),
    .i_rx_reset            (i_rx_reset),
    .i_pll_sleep_pin       (i_pll_sleep_pin),
    .o_tx_serializer_rst   (o_tx_serializer_rst),
    .o_tx_pll_rst          (o_tx_pll_rst),
    .o_rx_deserializer_rst (o_rx_deserializer_rst),
    .o_rx_pll_rst          (o_rx_pll_rst),
    .o_tx_pll_sleep        (o_tx_pll_sleep),
    .o_rx_pll_sleep        (o_rx_pll_sleep),
    .o_io_drive_en         (o_io_drive_en),
    .o_fabric_rst          (o_fabric_rst),
    .o_sync_release_act    (o_sync_release_act),
    .o_core_ready          (o_core_ready)
);
